//--- verilog/anp_status_regs.sv
// Partner ability and expansion status registers, copper and fiber views
`timescale 1ns/1ps
// What this block does
// - Copper bit 10 shows partner symmetric pause
// - Copper bits 9:5 show partner speed modes
// - Copper bits 4:0 hold partner selector
// - Fiber bits 15,14 match copper ones
// - Fiber bits 13:12 show partner remote fault
// - Copper bit 13 remote fault mapped by mask and OR
// - Fiber bit 8 shows asymmetric pause
// - Fiber bit 7 shows symmetric pause
// - Fiber bits 6:5 show gigabit ability both media
// - Parallel detection fault sets copper expansion bit 4
// - Fault bit latched until expansion read
// - Copper expansion bit 3 shows partner next-page able
// - Copper local next-page bit fixed one
// - Page received set on every page event
// - Page received latched until expansion read
// - Copper expansion bit 0 shows partner negotiation able
// - Expansion bits 3 and 0 (partner next-page and negotiation able) valid only copper link up
// - Fiber local next-page bit fixed zero
// - Fiber page received; next pages copper only
// - Copper bit 15 partner next-page request
// - Bit 14 partner acknowledge
module anp_status_regs
  import anp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  anp_req_s         req_i,
  input  wire logic        fiber_view,
  input  anp_page_s        page_i,
  input  anp_event_s       evt_i,
  input  wire logic        gig_copper_rx,
  input  wire logic [1:0]  rf_map_mask,
  input  wire logic        rf_map_or,
  output logic [15:0]      rd_data,
  output logic             rd_hit
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    anp_page_s   page;
    logic [1:0]  gig_fiber;
    logic        lpnp;
    logic        lpan;
    logic [15:0] rdata;
    logic        hit;
  } anp_state_s;

  anp_state_s  st_q;
  anp_state_s  st_d;
  logic        exp_read;
  logic        pdf_flag;
  logic        pr_flag;
  logic [15:0] partner_img;
  logic [15:0] exp_img;

  assign exp_read = req_i.rd && (req_i.addr == ANP_REG_EXPANSION_OFS);

  // ----------------------------------------------------------------
  // Latch-high flags
  // ----------------------------------------------------------------
  anp_latch_high u_pdf (
    .clk    (clk),
    .srst   (srst),
    .set_i  (evt_i.pdf_event),
    .clr_i  (exp_read),
    .flag_o (pdf_flag)
  );

  anp_latch_high u_pr (
    .clk    (clk),
    .srst   (srst),
    .set_i  (evt_i.page_event),
    .clr_i  (exp_read),
    .flag_o (pr_flag)
  );

  anp_view_mux u_mux (
    .page_i       (st_q.page),
    .gig_copper_i (gig_copper_rx),
    .gig_fiber_i  (st_q.gig_fiber),
    .fiber_view_i (fiber_view),
    .pdf_i        (pdf_flag),
    .pr_i         (pr_flag),
    .lpnp_i       (st_q.lpnp),
    .lpan_i       (st_q.lpan),
    .rf_mask_i    (rf_map_mask),
    .rf_or_i      (rf_map_or),
    .partner_o    (partner_img),
    .expansion_o  (exp_img)
  );

  // ----------------------------------------------------------------
  // Capture and read
  // ----------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    st_d.hit = 1'b0;
    if (evt_i.page_event) begin
      st_d.page = page_i;
      // Next pages come only from copper negotiation
      if (evt_i.fiber_page) begin
        st_d.page.next_page = 1'b0;
        st_d.gig_fiber      = page_i.gig_ability;
      end
    end
    // Copper-only flags drop when the copper link falls
    st_d.lpnp = evt_i.copper_link_up & evt_i.partner_np_able;
    st_d.lpan = evt_i.copper_link_up & evt_i.partner_an_able;
    if (req_i.rd) begin
      st_d.hit = 1'b1;
      case (req_i.addr)
        ANP_REG_PARTNER_OFS:   st_d.rdata = partner_img;
        ANP_REG_EXPANSION_OFS: st_d.rdata = exp_img;
        default:               st_d.hit   = 1'b0;
      endcase
    end
    // Writes change no state; a write with a read keeps the old read data
    if (req_i.wr) begin
      st_d.rdata = st_q.rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rdata;
  assign rd_hit  = st_q.hit;

endmodule : anp_status_regs

//--- include/anp_pkg.sv
// Package: register map, field layout and carriers for partner status registers
package anp_pkg;

  localparam logic [4:0]  ANP_REG_PARTNER_OFS   = 5'h05;
  localparam logic [4:0]  ANP_REG_EXPANSION_OFS = 5'h06;
  localparam logic [15:0] ANP_PARTNER_RST       = 16'h0000;
  localparam logic [15:0] ANP_EXP_RST_COPPER    = 16'h0004;
  localparam logic [15:0] ANP_EXP_RST_FIBER     = 16'h0000;

  // Copper view fields
  localparam int ANP_C_NP      = 15;
  localparam int ANP_C_ACK     = 14;
  localparam int ANP_C_RF      = 13;
  localparam int ANP_C_ASYM    = 11;
  localparam int ANP_C_SYM     = 10;
  localparam int ANP_C_ABIL_LO = 5;
  localparam int ANP_C_SEL_LO  = 0;
  // Fiber view fields
  localparam int ANP_F_RF_LO   = 12;
  localparam int ANP_F_ASYM    = 8;
  localparam int ANP_F_SYM     = 7;
  localparam int ANP_F_GIG_LO  = 5;
  // Expansion fields
  localparam int ANP_E_PDF     = 4;
  localparam int ANP_E_LPNP    = 3;
  localparam int ANP_E_LNP     = 2;
  localparam int ANP_E_PR      = 1;
  localparam int ANP_E_LPAN    = 0;

  localparam logic ANP_LOCAL_NP_COPPER = 1'b1;
  localparam logic ANP_LOCAL_NP_FIBER  = 1'b0;

  // Received page content from the negotiation engines
  typedef struct packed {
    logic       next_page;
    logic       ack;
    logic [1:0] remote_fault;
    logic       asym_pause;
    logic       sym_pause;
    logic [4:0] tech_ability;
    logic [4:0] selector;
    logic [1:0] gig_ability;
  } anp_page_s;

  // Negotiation events and status from the state machines
  typedef struct packed {
    logic pdf_event;
    logic page_event;
    logic fiber_page;
    logic partner_np_able;
    logic partner_an_able;
    logic copper_link_up;
  } anp_event_s;

  // Management read/write request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [4:0] addr;
  } anp_req_s;

endpackage : anp_pkg

//--- verilog/anp_latch_high.sv
// Latch-high status flag, cleared by a register read; set wins over clear
`timescale 1ns/1ps
module anp_latch_high
  import anp_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  typedef struct packed {
    logic flag;
  } anp_lh_state_s;

  anp_lh_state_s st_q;
  anp_lh_state_s st_d;

  always_comb begin
    st_d = st_q;
    if (clr_i) begin
      st_d.flag = 1'b0;
    end
    // Event in the read cycle stays visible for the next read
    if (set_i) begin
      st_d.flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag_o = st_q.flag;

endmodule : anp_latch_high

//--- verilog/anp_view_mux.sv
// Builds copper and fiber images of partner ability and expansion registers
`timescale 1ns/1ps
module anp_view_mux
  import anp_pkg::*;
(
  input  anp_page_s   page_i,
  input  logic        gig_copper_i,
  input  logic [1:0]  gig_fiber_i,
  input  logic        fiber_view_i,
  input  logic        pdf_i,
  input  logic        pr_i,
  input  logic        lpnp_i,
  input  logic        lpan_i,
  input  logic [1:0]  rf_mask_i,
  input  logic        rf_or_i,
  output logic [15:0] partner_o,
  output logic [15:0] expansion_o
);

  logic       copper_rf;

  // Two-bit fault folded to one copper bit via mask and OR control
  assign copper_rf = rf_or_i ? |(page_i.remote_fault & rf_mask_i)
                             : &(page_i.remote_fault | ~rf_mask_i) & |rf_mask_i;

  always_comb begin
    partner_o   = ANP_PARTNER_RST;
    expansion_o = '0;
    partner_o[ANP_C_NP]  = page_i.next_page;
    partner_o[ANP_C_ACK] = page_i.ack;
    if (fiber_view_i) begin
      partner_o[ANP_F_RF_LO +: 2] = page_i.remote_fault;
      partner_o[ANP_F_ASYM]       = page_i.asym_pause;
      partner_o[ANP_F_SYM]        = page_i.sym_pause;
      partner_o[ANP_F_GIG_LO +: 2] = gig_fiber_i | {2{gig_copper_i}} & page_i.gig_ability;
      expansion_o[ANP_E_LNP] = ANP_LOCAL_NP_FIBER;
      expansion_o[ANP_E_PR]  = pr_i;
    end else begin
      partner_o[ANP_C_RF]   = copper_rf;
      partner_o[ANP_C_ASYM] = page_i.asym_pause;
      partner_o[ANP_C_SYM]  = page_i.sym_pause;
      partner_o[ANP_C_ABIL_LO +: 5] = page_i.tech_ability;
      partner_o[ANP_C_SEL_LO +: 5]  = page_i.selector;
      expansion_o[ANP_E_PDF]  = pdf_i;
      expansion_o[ANP_E_LPNP] = lpnp_i;
      expansion_o[ANP_E_LNP]  = ANP_LOCAL_NP_COPPER;
      expansion_o[ANP_E_PR]   = pr_i;
      expansion_o[ANP_E_LPAN] = lpan_i;
    end
  end

endmodule : anp_view_mux

//--- dv/anp_status_regs_assertions.sv
// Checker for partner status register reads
`timescale 1ns/1ps
module anp_status_regs_assertions
  import anp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  anp_req_s         req_i,
  input  wire logic        fiber_view,
  input  anp_event_s       evt_i,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_hit
);
  logic rd5;
  logic rd6;
  logic pdf_q;
  logic pr_q;
  assign rd5 = req_i.rd && (req_i.addr == ANP_REG_PARTNER_OFS);
  assign rd6 = req_i.rd && (req_i.addr == ANP_REG_EXPANSION_OFS);
  // ----
  // Reference latch-high flags; set wins over read
  // ----
  always_ff @(posedge clk) begin
    pdf_q <= !srst && (evt_i.pdf_event || (pdf_q && !rd6));
    pr_q  <= !srst && (evt_i.page_event || (pr_q && !rd6));
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_hit_exact: assert property (rd_hit == $past(rd5 || rd6))
    else $error("rd_hit does not follow a mapped read");
  a_unmapped_hold: assert property (
    (req_i.rd || req_i.wr) && !rd5 && !rd6 |=> $stable(rd_data))
    else $error("rd_data changed without a mapped read");
  a_np_copper: assert property (
    rd6 && !fiber_view |=> rd_data[15:5] == 11'h0 && rd_data[ANP_E_LNP])
    else $error("copper expansion fixed bits wrong");
  a_np_fiber: assert property (
    rd6 && fiber_view |=> rd_data[15:2] == 14'h0 && !rd_data[0])
    else $error("fiber expansion fixed bits wrong");
  a_pdf_latch: assert property (
    rd6 && !fiber_view && !evt_i.pdf_event |=> rd_data[ANP_E_PDF] == $past(pdf_q))
    else $error("parallel fault flag wrong");
  a_pr_latch: assert property (
    rd6 && !evt_i.page_event |=> rd_data[ANP_E_PR] == $past(pr_q))
    else $error("page received flag wrong");
  a_link_gate: assert property (
    rd6 && !fiber_view && !evt_i.copper_link_up && !$past(evt_i.copper_link_up)
    |=> !rd_data[ANP_E_LPNP] && !rd_data[ANP_E_LPAN])
    else $error("partner ability shown with copper link down");
  a_fiber_rsv: assert property (
    rd5 && fiber_view |=> rd_data[11:9] == 3'h0 && rd_data[4:0] == 5'h0)
    else $error("fiber partner reserved bits set");
  a_copper_rsv: assert property (rd5 && !fiber_view |=> !rd_data[12])
    else $error("copper partner reserved bit set");
endmodule : anp_status_regs_assertions

bind anp_status_regs anp_status_regs_assertions u_chk (.clk(clk), .srst(srst), .req_i(req_i),
  .fiber_view(fiber_view), .evt_i(evt_i), .rd_data(rd_data), .rd_hit(rd_hit));

//--- dv/anp_host_model.sv
// Management host model issuing register requests
`timescale 1ns/1ps
module anp_host_model
  import anp_pkg::*;
(
  input  wire logic clk,
  output anp_req_s  req_o
);
  initial req_o = '0;
  // One-cycle request pulse, so a held read never repeats behind later stimulus
  task automatic issue(input logic rd, input logic wr, input logic [4:0] addr);
    @(posedge clk);
    req_o <= '{rd: rd, wr: wr, addr: addr};
    @(posedge clk);
    req_o <= '0;
  endtask : issue
endmodule : anp_host_model

//--- dv/tb_top.sv
// Testbench for partner status registers
`timescale 1ns/1ps
module tb_top
  import anp_pkg::*;
;
  logic        clk = 0, srst = 1, fiber_view = 0, gig_copper_rx = 1, rf_map_or = 0, rfc;
  logic [1:0]  rf_map_mask = 2'h3, m;
  anp_page_s   page_i = '0, p;
  anp_event_s  evt_i = '0;
  anp_req_s    req;
  logic [15:0] rd_data;
  logic        rd_hit;
  logic [31:0] rng = 32'h8E15;
  logic [15:0] expq[$];
  int          num_errors = 0, tests_run = 0, cyc = 0;
  anp_host_model host (.clk(clk), .req_o(req));
  anp_status_regs dut (.clk(clk), .srst(srst), .req_i(req), .fiber_view(fiber_view),
    .page_i(page_i), .evt_i(evt_i), .gig_copper_rx(gig_copper_rx), .rf_map_mask(rf_map_mask),
    .rf_map_or(rf_map_or), .rd_data(rd_data), .rd_hit(rd_hit));
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    expq.push_back(e);
    host.issue(1'b1, 1'b0, a);
  endtask : rd
  // View flips only behind an idle request, so no read sees it early
  task automatic view(input logic v);
    host.issue(1'b0, 1'b0, 5'h1A);
    fiber_view <= v;
  endtask : view
  task automatic send(input logic fib);
    @(posedge clk);
    evt_i.page_event <= 1'b1;
    evt_i.fiber_page <= fib;
    @(posedge clk);
    evt_i.page_event <= 1'b0;
  endtask : send
  // ----
  // Answer watcher and hang guard
  // ----
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      end_sim();
    end else if (rd_hit === 1'b1) begin
      check("rd_data", rd_data, expq.size() ? expq.pop_front() : 'x);
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(ANP_REG_EXPANSION_OFS, ANP_EXP_RST_COPPER);
    rd(ANP_REG_PARTNER_OFS, ANP_PARTNER_RST);
    host.issue(1'b1, 1'b0, 5'h07);
    for (int i = 0; i < 6; i++) begin
      view(1'b0);
      rng = xs(rng);
      p = rng[17:0];
      p.gig_ability = 2'h3;
      m = 2'(i / 2 + 1);
      rfc = i[0] ? |(p.remote_fault & m) : ((p.remote_fault & m) == m);
      page_i <= p;
      rf_map_or <= i[0];
      rf_map_mask <= m;
      gig_copper_rx <= i[1];
      send(1'b0);
      rd(5'h05, {p.next_page, p.ack, rfc, 1'b0, p.asym_pause, p.sym_pause, p.tech_ability,
        p.selector});
      rd(5'h06, 16'h0006);
      rd(5'h06, 16'h0004);
      view(1'b1);
      rd(5'h05, {p.next_page, p.ack, p.remote_fault, 3'h0, p.asym_pause, p.sym_pause,
        {2{i[1]}}, 5'h0});
      rd(5'h06, 16'h0000);
    end
    view(1'b0);
    @(posedge clk);
    evt_i.pdf_event <= 1'b1;
    @(posedge clk);
    evt_i.pdf_event <= 1'b0;
    host.issue(1'b0, 1'b1, 5'h06);
    rd(5'h06, 16'h0014);
    rd(5'h06, 16'h0004);
    view(1'b0);
    evt_i.partner_np_able <= 1'b1;
    evt_i.partner_an_able <= 1'b1;
    evt_i.copper_link_up <= 1'b1;
    rd(5'h06, 16'h000D);
    view(1'b0);
    evt_i.copper_link_up <= 1'b0;
    rd(5'h06, 16'h0004);
    view(1'b1);
    rd(5'h06, ANP_EXP_RST_FIBER);
    send(1'b1);
    rd(5'h06, 16'h0002);
    rd(5'h05, {1'b0, p.ack, p.remote_fault, 3'h0, p.asym_pause, p.sym_pause, 2'h3,
      5'h0});
    host.issue(1'b0, 1'b0, 5'h1A);
    repeat (3) @(posedge clk);
    $display("register read tests done");
    end_sim();
  end
endmodule : tb_top
